// [rtl/pdd_pkg.sv]
// Shared constants and state types for the pulse dialer digit store
package pdd_pkg;

    // Core clock
    localparam int unsigned CLK_PERIOD_NS      = 4;

    // Dial pulse period at 10 pps; the internal timebase runs at 30 ticks per pulse period
    localparam int unsigned DP_PERIOD_NS       = 100_000_000;
    localparam int unsigned TICKS_PER_DP       = 30;
    localparam int unsigned TICK_CYCLES        = DP_PERIOD_NS / TICKS_PER_DP / CLK_PERIOD_NS;

    // Standby reset delay after the hook enable input goes high, and clock enable delay after it goes low
    localparam int unsigned RESET_DELAY_MS     = 223;
    localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned CLK_EN_MS          = 1;
    localparam int unsigned CLK_EN_CYCLES      = CLK_EN_MS * 1_000_000 / CLK_PERIOD_NS;

    // Timebase tick counts
    localparam logic [8:0] MAKE_HI_TICKS       = 9'h00C;  // 40/60 split
    localparam logic [8:0] BREAK_HI_TICKS      = 9'h012;
    localparam logic [8:0] MAKE_LO_TICKS       = 9'h00A;  // 33.3/66.6 split
    localparam logic [8:0] BREAK_LO_TICKS      = 9'h014;
    localparam logic [8:0] IDP_TICKS           = 9'h0F0;  // 8 pulse periods
    localparam logic [8:0] PRE_TICKS           = 9'h108;  // 1.1 x interdigit pause
    localparam logic [2:0] DEB_CLOSE_TICKS     = 3'h4;
    localparam logic [2:0] DEB_OPEN_TICKS      = 3'h3;

    // Digit store geometry
    localparam int unsigned RAM_DEPTH          = 32;
    localparam int unsigned ADDR_W             = 5;
    localparam int unsigned CODE_W             = 4;
    localparam logic [5:0] PTR_RESET           = 6'h00;
    localparam logic [5:0] PTR_AFTER_FIRST     = 6'h01;

    // Keycodes; digit zero carries the value ten so the pulse count equals the code
    localparam logic [3:0] KEY_ZERO           = 4'hA;
    localparam logic [3:0] KEY_STAR           = 4'hB;
    localparam logic [3:0] KEY_HASH           = 4'hC;
    localparam logic [3:0] CODE_PAUSE         = 4'hF;

    typedef enum logic [1:0] {
        KB_IDLE,
        KB_CLOSE,
        KB_HELD,
        KB_OPEN
    } pdd_kb_state_t;

    typedef enum logic [2:0] {
        DS_IDLE,
        DS_PRE,
        DS_FETCH,
        DS_GAP,
        DS_BREAK,
        DS_MAKE,
        DS_IDP,
        DS_PAUSE
    } pdd_dial_state_t;

endpackage

// [rtl/pdd_ram.sv]
// Digit store memory: 32 keycodes, synchronous write, registered read
`timescale 1ns/10ps
module pdd_ram (
    input  wire logic                          ref_clk_i,
    input  wire logic                          wr_en_i,
    input  wire logic [pdd_pkg::ADDR_W-1:0]    wr_addr_i,
    input  wire logic [pdd_pkg::CODE_W-1:0]    wr_data_i,
    input  wire logic [pdd_pkg::ADDR_W-1:0]    rd_addr_i,
    output logic      [pdd_pkg::CODE_W-1:0]    rd_data_o
);

    // No reset: contents survive standby and must keep the last number
    logic [pdd_pkg::CODE_W-1:0] mem_q [pdd_pkg::RAM_DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        rd_data_o <= mem_q[rd_addr_i];
    end

endmodule // pdd_ram

// [rtl/pdd_dialer.sv]
// Pulse dialer core: keypad debounce, digit store, redial, pauses and line pulse timing
`timescale 1ns/10ps
module pdd_dialer #(
    parameter int unsigned TICK_CYCLES_P        = pdd_pkg::TICK_CYCLES,
    parameter int unsigned RESET_DELAY_CYCLES_P = pdd_pkg::RESET_DELAY_CYCLES,
    parameter int unsigned CLK_EN_CYCLES_P      = pdd_pkg::CLK_EN_CYCLES
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] column_input_i,
    input  wire logic [3:0] row_input_i,
    input  wire logic       hook_en_n_i,
    input  wire logic       mark_space_i,
    output logic            dial_pulse_out_o,
    output logic            mute_out_n_o,
    output logic            osc_run_o,
    output logic            pull_en_o,
    output logic            standby_o
);

    // Pin synchronisers: first stage is read only by the second
    logic [8:0] pin_meta_q;
    logic [8:0] pin_sync_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_meta_q <= 9'h1C0;
            pin_sync_q <= 9'h1C0;
        end else begin
            pin_meta_q <= {hook_en_n_i, mark_space_i, 1'b0, column_input_i, row_input_i[2:0]};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Fourth row needs its own pair to keep the vector tidy above
    logic row3_meta_q;
    logic row3_sync_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            row3_meta_q <= 1'b0;
            row3_sync_q <= 1'b0;
        end else begin
            row3_meta_q <= row_input_i[3];
            row3_sync_q <= row3_meta_q;
        end
    end

    logic       hook_n_s;
    logic       mark_space_s;
    logic [2:0] col_s;
    logic [3:0] row_s;

    assign hook_n_s     = pin_sync_q[8];
    assign mark_space_s = pin_sync_q[7];
    assign col_s        = pin_sync_q[5:3];
    assign row_s        = {row3_sync_q, pin_sync_q[2:0]};

    // Hook enable: standby entry after a long high, generator enable after a low
    logic        standby_q;
    logic [31:0] hi_cnt_q;
    logic [31:0] en_cnt_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            standby_q <= 1'b1;
            hi_cnt_q  <= 32'h0000_0000;
            en_cnt_q  <= 32'h0000_0000;
        end else if (hook_n_s) begin
            en_cnt_q <= 32'h0000_0000;
            // Short highs only restart the enable count; only a full reset delay forces standby
            if (hi_cnt_q == RESET_DELAY_CYCLES_P - 1) begin
                standby_q <= 1'b1;
            end else begin
                hi_cnt_q <= hi_cnt_q + 32'h0000_0001;
            end
        end else begin
            hi_cnt_q <= 32'h0000_0000;
            if (standby_q) begin
                if (en_cnt_q == CLK_EN_CYCLES_P - 1) begin
                    standby_q <= 1'b0;
                end else begin
                    en_cnt_q <= en_cnt_q + 32'h0000_0001;
                end
            end
        end
    end

    // Soft reset for everything except the pin synchronisers, hook enable counters, write pointer, overflow mark and store
    logic srst;
    assign srst = !rst_n_i || standby_q;

    // Keypad decode
    logic       key_valid;
    logic       any_contact;
    logic [3:0] key_code;
    logic [1:0] row_idx;
    logic [1:0] col_idx;
    logic [3:0] key_idx;

    always_comb begin
        row_idx = 2'h0;
        col_idx = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (row_s[i]) begin
                row_idx = 2'(i);
            end
        end
        for (int j = 0; j < 3; j++) begin
            if (col_s[j]) begin
                col_idx = 2'(j);
            end
        end
        key_idx = 4'({row_idx, 1'b0}) + 4'(row_idx) + 4'(col_idx);
        case (key_idx)
            4'h9:    key_code = pdd_pkg::KEY_STAR;
            4'hA:    key_code = pdd_pkg::KEY_ZERO;
            4'hB:    key_code = pdd_pkg::KEY_HASH;
            default: key_code = key_idx + 4'h1;
        endcase
    end

    // Two keys at once never form a single column/row pair, so they are rejected
    assign key_valid   = $onehot(col_s) && $onehot(row_s);
    assign any_contact = (|col_s) && (|row_s);

    // Internal timebase, gated like the RC oscillator it replaces
    logic                    osc_run_q;
    logic [31:0]             tick_cnt_q;
    logic                    tick;
    pdd_pkg::pdd_kb_state_t   kb_state_q;
    pdd_pkg::pdd_dial_state_t ds_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst) begin
            osc_run_q <= 1'b0;
        end else begin
            osc_run_q <= any_contact || (kb_state_q != pdd_pkg::KB_IDLE) || (ds_q != pdd_pkg::DS_IDLE);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst || !osc_run_q || tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    assign tick = osc_run_q && (tick_cnt_q == TICK_CYCLES_P - 1);

    // Debounce: press counted from the first tick after closure, hence one tick of spread
    logic [2:0] kb_cnt_q;
    logic [3:0] kb_cand_q;
    logic       key_ev_q;
    logic [3:0] key_code_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst) begin
            kb_state_q <= pdd_pkg::KB_IDLE;
            kb_cnt_q   <= 3'h0;
            kb_cand_q  <= 4'h0;
            key_ev_q   <= 1'b0;
            key_code_q <= 4'h0;
        end else begin
            key_ev_q <= 1'b0;
            case (kb_state_q)
                pdd_pkg::KB_IDLE: begin
                    kb_cnt_q <= 3'h0;
                    if (key_valid) begin
                        kb_cand_q  <= key_code;
                        kb_state_q <= pdd_pkg::KB_CLOSE;
                    end
                end
                pdd_pkg::KB_CLOSE: begin
                    if (!key_valid || key_code != kb_cand_q) begin
                        kb_state_q <= pdd_pkg::KB_IDLE;
                    end else if (tick) begin
                        if (kb_cnt_q == pdd_pkg::DEB_CLOSE_TICKS - 3'h1) begin
                            key_ev_q   <= 1'b1;
                            key_code_q <= kb_cand_q;
                            kb_state_q <= pdd_pkg::KB_HELD;
                        end else begin
                            kb_cnt_q <= kb_cnt_q + 3'h1;
                        end
                    end
                end
                pdd_pkg::KB_HELD: begin
                    kb_cnt_q <= 3'h0;
                    if (!any_contact) begin
                        kb_state_q <= pdd_pkg::KB_OPEN;
                    end
                end
                pdd_pkg::KB_OPEN: begin
                    if (any_contact) begin
                        kb_state_q <= pdd_pkg::KB_HELD;
                    end else if (tick) begin
                        if (kb_cnt_q == pdd_pkg::DEB_OPEN_TICKS - 3'h1) begin
                            kb_state_q <= pdd_pkg::KB_IDLE;
                        end else begin
                            kb_cnt_q <= kb_cnt_q + 3'h1;
                        end
                    end
                end
                default: kb_state_q <= pdd_pkg::KB_IDLE;
            endcase
        end
    end

    // Key dispatch
    logic       first_q;
    logic       redial_q;
    logic       overflow_q;
    logic [5:0] wp_q;
    logic [5:0] rp_q;
    logic       wr_en;
    logic [3:0] wr_data;
    logic       start_redial;
    logic       pause_rel;
    logic       to_extra;

    always_comb begin
        wr_en        = 1'b0;
        start_redial = 1'b0;
        pause_rel    = 1'b0;
        to_extra     = 1'b0;
        wr_data      = (key_code_q == pdd_pkg::KEY_HASH) ? pdd_pkg::CODE_PAUSE : key_code_q;
        if (key_ev_q && key_code_q != pdd_pkg::KEY_STAR) begin
            if (first_q) begin
                if (key_code_q == pdd_pkg::KEY_HASH) begin
                    start_redial = !overflow_q;
                end else begin
                    wr_en = 1'b1;
                end
            end else if (redial_q) begin
                if (key_code_q == pdd_pkg::KEY_HASH) begin
                    pause_rel = 1'b1;
                end else begin
                    to_extra = 1'b1;
                end
            end else begin
                wr_en = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst) begin
            first_q  <= 1'b1;
            redial_q <= 1'b0;
        end else if (start_redial) begin
            first_q  <= 1'b0;
            redial_q <= 1'b1;
        end else if (wr_en) begin
            first_q <= 1'b0;
        end
    end

    // Write pointer survives standby; only the power reset clears it, and a new call's first digit restarts it at PTR_AFTER_FIRST
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wp_q       <= pdd_pkg::PTR_RESET;
            overflow_q <= 1'b0;
        end else if (wr_en) begin
            if (first_q) begin
                wp_q       <= pdd_pkg::PTR_AFTER_FIRST;
                overflow_q <= 1'b0;
            end else begin
                wp_q <= wp_q + 6'h01;
                if (wp_q[5]) begin
                    overflow_q <= 1'b1;
                end
            end
        end
    end

    logic [3:0] rd_data;
    logic [4:0] wr_addr;

    assign wr_addr = first_q ? 5'h00 : wp_q[4:0];

    pdd_ram u_ram (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (wr_addr),
        .wr_data_i (wr_data),
        .rd_addr_i (rp_q[4:0]),
        .rd_data_o (rd_data)
    );

    // One-deep hold for an extra key typed during redial; a second one while it waits is dropped
    logic       extra_valid_q;
    logic [3:0] extra_code_q;
    logic       take_extra;
    logic       take_ram;
    logic       ram_pending;
    logic [5:0] pending;

    assign pending     = wp_q - rp_q;
    assign ram_pending = !first_q && (pending != 6'h00);

    always_ff @(posedge ref_clk_i) begin
        if (srst) begin
            extra_valid_q <= 1'b0;
            extra_code_q  <= 4'h0;
        end else if (to_extra && !extra_valid_q) begin
            extra_valid_q <= 1'b1;
            extra_code_q  <= key_code_q;
        end else if (take_extra) begin
            extra_valid_q <= 1'b0;
        end
    end

    // Dial sequencer
    logic [8:0] tcnt_q;
    logic [3:0] pulses_q;
    logic       last_pause_q;
    logic       mute_n_q;
    logic       dp_q;
    logic [3:0] cur_code;
    logic [8:0] make_ticks;
    logic [8:0] break_ticks;
    logic       any_pending;

    assign take_ram    = (ds_q == pdd_pkg::DS_FETCH) && ram_pending;
    assign take_extra  = (ds_q == pdd_pkg::DS_FETCH) && !ram_pending && extra_valid_q;
    assign cur_code    = ram_pending ? rd_data : extra_code_q;
    assign any_pending = ram_pending || extra_valid_q;
    assign make_ticks  = mark_space_s ? pdd_pkg::MAKE_HI_TICKS : pdd_pkg::MAKE_LO_TICKS;
    assign break_ticks = mark_space_s ? pdd_pkg::BREAK_HI_TICKS : pdd_pkg::BREAK_LO_TICKS;

    always_ff @(posedge ref_clk_i) begin
        if (srst) begin
            rp_q <= pdd_pkg::PTR_RESET;
        end else if (start_redial || (wr_en && first_q)) begin
            rp_q <= pdd_pkg::PTR_RESET;
        end else if (take_ram) begin
            rp_q <= rp_q + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst) begin
            ds_q         <= pdd_pkg::DS_IDLE;
            tcnt_q       <= 9'h000;
            pulses_q     <= 4'h0;
            last_pause_q <= 1'b0;
            mute_n_q     <= 1'b1;
            dp_q         <= 1'b1;
        end else begin
            case (ds_q)
                pdd_pkg::DS_IDLE: begin
                    tcnt_q   <= 9'h000;
                    mute_n_q <= 1'b1;
                    dp_q     <= 1'b1;
                    if (any_pending) begin
                        ds_q     <= pdd_pkg::DS_PRE;
                        mute_n_q <= 1'b0;
                    end
                end
                pdd_pkg::DS_PRE: begin
                    if (tick) begin
                        if (tcnt_q == pdd_pkg::PRE_TICKS - 9'h001) begin
                            ds_q <= pdd_pkg::DS_FETCH;
                        end else begin
                            tcnt_q <= tcnt_q + 9'h001;
                        end
                    end
                end
                pdd_pkg::DS_FETCH: begin
                    tcnt_q <= 9'h000;
                    if (!any_pending) begin
                        ds_q     <= pdd_pkg::DS_IDLE;
                        mute_n_q <= 1'b1;
                    end else if (cur_code == pdd_pkg::CODE_PAUSE) begin
                        last_pause_q <= 1'b1;
                        if (redial_q && !last_pause_q) begin
                            ds_q     <= pdd_pkg::DS_PAUSE;
                            mute_n_q <= 1'b1;
                        end else begin
                            ds_q <= pdd_pkg::DS_GAP;
                        end
                    end else begin
                        last_pause_q <= 1'b0;
                        pulses_q     <= cur_code;
                        dp_q         <= 1'b0;
                        ds_q         <= pdd_pkg::DS_BREAK;
                    end
                end
                pdd_pkg::DS_GAP: begin
                    // Lets the store read settle on the advanced read pointer
                    ds_q <= pdd_pkg::DS_FETCH;
                end
                pdd_pkg::DS_BREAK: begin
                    if (tick) begin
                        if (tcnt_q == break_ticks - 9'h001) begin
                            tcnt_q <= 9'h000;
                            dp_q   <= 1'b1;
                            ds_q   <= pdd_pkg::DS_MAKE;
                        end else begin
                            tcnt_q <= tcnt_q + 9'h001;
                        end
                    end
                end
                pdd_pkg::DS_MAKE: begin
                    if (tick) begin
                        if (tcnt_q == make_ticks - 9'h001) begin
                            tcnt_q   <= 9'h000;
                            pulses_q <= pulses_q - 4'h1;
                            if (pulses_q == 4'h1) begin
                                ds_q     <= pdd_pkg::DS_IDP;
                                mute_n_q <= 1'b1;
                            end else begin
                                dp_q <= 1'b0;
                                ds_q <= pdd_pkg::DS_BREAK;
                            end
                        end else begin
                            tcnt_q <= tcnt_q + 9'h001;
                        end
                    end
                end
                pdd_pkg::DS_IDP: begin
                    if (tick) begin
                        if (tcnt_q == pdd_pkg::IDP_TICKS - 9'h001) begin
                            tcnt_q <= 9'h000;
                            if (any_pending) begin
                                ds_q     <= pdd_pkg::DS_FETCH;
                                mute_n_q <= 1'b0;
                            end else begin
                                ds_q <= pdd_pkg::DS_IDLE;
                            end
                        end else begin
                            tcnt_q <= tcnt_q + 9'h001;
                        end
                    end
                end
                pdd_pkg::DS_PAUSE: begin
                    // Unlimited wait; only the pause key ends it
                    if (pause_rel) begin
                        ds_q     <= pdd_pkg::DS_GAP;
                        mute_n_q <= 1'b0;
                    end
                end
                default: ds_q <= pdd_pkg::DS_IDLE;
            endcase
        end
    end

    assign dial_pulse_out_o = dp_q;
    assign mute_out_n_o     = mute_n_q;
    assign osc_run_o        = osc_run_q;
    assign pull_en_o        = !standby_q;
    assign standby_o        = standby_q;

endmodule // pdd_dialer

// [bench/pdd_dialer_assertions.sv]
// Port-level timing and standby checks for the pulse dialer
`timescale 1ns/10ps
module pdd_dialer_assertions #(
    parameter int unsigned TICK_CYCLES_P        = 4,
    parameter int unsigned RESET_DELAY_CYCLES_P = 200,
    parameter int unsigned CLK_EN_CYCLES_P      = 20
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] column_input_i,
    input  wire logic [3:0] row_input_i,
    input  wire logic       hook_en_n_i,
    input  wire logic       mark_space_i,
    input  wire logic       dial_pulse_out_o,
    input  wire logic       mute_out_n_o,
    input  wire logic       osc_run_o,
    input  wire logic       pull_en_o,
    input  wire logic       standby_o
);
    localparam int unsigned T = TICK_CYCLES_P;
    int unsigned lo_q;
    int unsigned hi_q;
    int unsigned mh_q;
    int unsigned hk_q;
    // One tick of slack: the fetch cycle shifts a pulse edge off the tick grid
    function automatic bit near(input int unsigned v, input int unsigned n);
        return v + T > n * T && v < n * T + T;
    endfunction
    always_ff @(posedge ref_clk_i) lo_q <= dial_pulse_out_o ? 0 : lo_q + 1;
    always_ff @(posedge ref_clk_i) hi_q <= dial_pulse_out_o ? hi_q + 1 : 0;
    always_ff @(posedge ref_clk_i) hk_q <= hook_en_n_i ? hk_q + 1 : 0;
    // A call starts from standby, so the first mute is not held to the pause
    always_ff @(posedge ref_clk_i) mh_q <= standby_o ? 1000 * T : (mute_out_n_o ? mh_q + 1 : 0);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_break_len: assert property ($rose(dial_pulse_out_o) |-> near(lo_q, mark_space_i ? 18 : 20))
        else $error("break length wrong");
    a_make_len: assert property ($fell(dial_pulse_out_o) && hi_q < 30 * T |-> near(hi_q, mark_space_i ? 12 : 10))
        else $error("make length wrong");
    a_pulse_muted: assert property ($fell(dial_pulse_out_o) |-> !mute_out_n_o)
        else $error("pulse while not muted");
    a_idp_hold: assert property ($fell(mute_out_n_o) |-> mh_q >= 239 * T)
        else $error("interdigit pause too short");
    a_standby_quiet: assert property (standby_o && $past(standby_o) |-> !osc_run_o && dial_pulse_out_o && mute_out_n_o)
        else $error("standby outputs not at rest");
    a_pull_follow: assert property (pull_en_o != standby_o)
        else $error("pull enable not inverse of standby");
    a_hook_standby: assert property (hk_q == RESET_DELAY_CYCLES_P + 8 |-> standby_o)
        else $error("long hook high gave no standby");
    a_short_hook: assert property ($rose(standby_o) |-> hk_q >= RESET_DELAY_CYCLES_P)
        else $error("standby from short hook pulse");
    c_standby: cover property ($rose(standby_o));
    c_mute: cover property ($fell(mute_out_n_o));
    c_break_lo: cover property ($fell(dial_pulse_out_o) && !mark_space_i);
endmodule // pdd_dialer_assertions
bind pdd_dialer pdd_dialer_assertions #(.TICK_CYCLES_P(TICK_CYCLES_P), .RESET_DELAY_CYCLES_P(RESET_DELAY_CYCLES_P),
    .CLK_EN_CYCLES_P(CLK_EN_CYCLES_P)) u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .column_input_i(column_input_i), .row_input_i(row_input_i), .hook_en_n_i(hook_en_n_i),
    .mark_space_i(mark_space_i), .dial_pulse_out_o(dial_pulse_out_o), .mute_out_n_o(mute_out_n_o),
    .osc_run_o(osc_run_o), .pull_en_o(pull_en_o), .standby_o(standby_o));

// [bench/pdd_pad_model.sv]
// Keypad matrix and line switch pulse counter on the far side of the dialer
`timescale 1ns/10ps
module pdd_pad_model (
    input  wire logic       ref_clk_i,
    input  wire logic [3:0] key_a_i,
    input  wire logic [3:0] key_b_i,
    input  wire logic       clr_i,
    input  wire logic       line_i,
    output logic      [2:0] column_o,
    output logic      [3:0] row_o,
    output logic      [7:0] brk_o
);
    logic line_q;
    // Index above 11 means open; a closed key ties one column to one row
    function automatic logic [6:0] tie(input logic [3:0] k);
        return (k < 4'hC) ? ((7'h08 << (k / 3)) | (7'h01 << (k % 3))) : 7'h00;
    endfunction
    assign {row_o, column_o} = tie(key_a_i) | tie(key_b_i);
    always_ff @(posedge ref_clk_i) line_q <= line_i;
    always_ff @(posedge ref_clk_i) brk_o <= clr_i ? 8'h00 : brk_o + {7'h00, line_q & ~line_i};
endmodule // pdd_pad_model

// [bench/pdd_dialer_tb_top.sv]
// Self-checking bench: keyed calls, redial, hang-ups and rejected key pairs
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module pdd_dialer_tb_top;
    logic       ref_clk_i = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic       hook      = 1'b1;
    logic       ms        = 1'b1;
    logic       clr       = 1'b1;
    logic [3:0] ka        = 4'hF;
    logic [3:0] kb        = 4'hF;
    logic [2:0] col;
    logic [3:0] row;
    logic [7:0] brk;
    logic       dial;
    logic       mute_n;
    logic       osc;
    logic       pull;
    logic       stby;
    int         bad_count = 0;
    int         tests_run = 0;
    int         d1;
    int         d2;
    int         d3;
    always #2 ref_clk_i = ~ref_clk_i;
    pdd_dialer #(.TICK_CYCLES_P(4), .RESET_DELAY_CYCLES_P(200), .CLK_EN_CYCLES_P(20)) dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .column_input_i(col), .row_input_i(row),
        .hook_en_n_i(hook), .mark_space_i(ms), .dial_pulse_out_o(dial), .mute_out_n_o(mute_n),
        .osc_run_o(osc), .pull_en_o(pull), .standby_o(stby));
    pdd_pad_model pad (.ref_clk_i(ref_clk_i), .key_a_i(ka), .key_b_i(kb), .clr_i(clr),
        .line_i(dial), .column_o(col), .row_o(row), .brk_o(brk));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    function automatic logic [3:0] key(input int d);
        return (d == 0) ? 4'hA : 4'(d - 1);
    endfunction
    function automatic int pulses(input int d);
        return (d == 0) ? 10 : d;
    endfunction
    task automatic press(input logic [3:0] a, input logic [3:0] b);
        ka = a;
        kb = b;
        cyc(40);
        ka = 4'hF;
        kb = 4'hF;
        cyc(40);
    endtask
    // Dialing is over once mute has rested high longer than one pause
    task automatic expect_pulses(input int n);
        int h;
        int t;
        h = 0;
        t = 0;
        while (h < 1100 && t < 30000) begin
            cyc(1);
            t++;
            h = (mute_n === 1'b1) ? h + 1 : 0;
        end
        // A dialer stuck with mute low must not slip through as a clean count
        if (t >= 30000) bad_count++;
        `CHK(brk, 8'(n))
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask
    task automatic hang();
        int t;
        hook = 1'b1;
        cyc(250);
        `CHK(stby, 1'b1)
        hook = 1'b0;
        t = 0;
        while (stby !== 1'b0 && t < 500) begin
            cyc(1);
            t++;
        end
        `CHK({pull, osc}, 2'b10)
        ms = 1'($urandom_range(0, 1));
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(98900));
        d1 = $urandom_range(0, 9);
        d2 = $urandom_range(0, 9);
        d3 = $urandom_range(0, 9);
        cyc(8);
        `CHK({dial, mute_n, osc, pull, stby}, 5'b11001)
        rst_n_i = 1'b1;
        clr = 1'b0;
        hang();
        hook = 1'b1;
        cyc(100);
        hook = 1'b0;
        cyc(20);
        `CHK(stby, 1'b0)
        press(key(d1), 4'hF);
        press(key(d2), 4'hF);
        expect_pulses(pulses(d1) + pulses(d2));
        hang();
        press(4'hB, 4'hF);
        expect_pulses(pulses(d1) + pulses(d2));
        press(key(d3), 4'hF);
        expect_pulses(pulses(d3));
        hang();
        press(4'hB, 4'hF);
        expect_pulses(pulses(d1) + pulses(d2));
        press(4'h0, 4'h4);
        expect_pulses(0);
        hang();
        press(key(d3), 4'hF);
        expect_pulses(pulses(d3));
        hang();
        press(4'hB, 4'hF);
        expect_pulses(pulses(d3));
        hang();
        press(key(d1), 4'hF);
        `CHK(osc, 1'b1)
        press(4'hB, 4'hF);
        press(4'hB, 4'hF);
        press(key(d2), 4'hF);
        expect_pulses(pulses(d1) + pulses(d2));
        hang();
        press(4'hB, 4'hF);
        // Replay halts at the stored pause until the pause key is pressed
        expect_pulses(pulses(d1));
        press(4'hB, 4'hF);
        expect_pulses(pulses(d2));
        print_verdict();
    end
    initial begin
        cyc(80000);
        bad_count++;
        print_verdict();
    end
endmodule // pdd_dialer_tb_top
